//--- main_control.sv
// main control register of the transceiver behind its 3-wire serial port
// assumes pins are asynchronous; converter samples come on sys_clk_i
`timescale 1ns/1ps
`default_nettype none
module main_control (
   input  wire logic       sys_clk_i,
   input  wire logic       rst_i,
   input  wire logic       sle_i,
   input  wire logic       sck_i,
   input  wire logic       sdata_i,
   output logic            sdata_o,
   output logic            sdata_oe_o,
   input  wire logic       synth_lock_flag_i,
   input  wire logic       demod_raw_i,
   input  wire logic       tx_data_i,
   input  wire logic       adc_valid_i,
   input  wire logic [5:0] adc_sample_i,
   output logic [31:0]     main_control_o,
   output logic            core_active_o,
   output logic            transmit_mode_o,
   output logic            recovered_clock_run_o,
   output logic            amplifier_on_o,
   output logic            wakeup_run_o,
   output logic            low_noise_min_gain_o,
   output logic [2:0]      transmit_power_level_o,
   output logic [1:0]      freq_reg_index_o,
   output logic            discriminator_narrow_o,
   output logic            slicer_internal_ref_o,
   output logic [1:0]      converter_route_o,
   output logic [5:0]      measured_signal_level_o,
   output logic [5:0]      measured_supply_o,
   output logic            demodulated_data_out_o,
   output logic            extended_mode_o
);
   import main_control_pkg::*;

   logic [5:0]       in_s1_ff;
   logic [5:0]       in_s2_ff;
   logic             sle_d_ff;
   logic             sck_d_ff;
   logic             sle_s;
   logic             sck_s;
   logic             sdin_s;
   logic             lock_s;
   logic             demod_s;
   logic             txd_s;
   logic             sle_fall;
   logic             sle_rise;
   logic             sck_rise;
   logic             sck_fall;

   serial_state_type state_ff;
   logic [2:0]       hdr_cnt_ff;
   logic [3:0]       addr_ff;
   logic [5:0]       wr_cnt_ff;
   logic [31:0]      wr_sr_ff;
   logic [31:0]      rd_sr_ff;
   logic             written_ff;
   logic             sdata_ff;
   logic             sdata_oe_ff;
   logic             commit_full;
   logic             commit_part;
   logic             soft_reset;
   logic [31:0]      main_control_ff;
   logic [31:0]      nxt_main_control;

   logic [5:0]       signal_level_ff;
   logic [5:0]       supply_ff;
   logic             rssi_sample;
   logic             gate_pass;

   // merges the top n written bits over the current contents
   function automatic logic [31:0] merge_bits(input logic [31:0] cur,
                                              input logic [31:0] sr,
                                              input logic [5:0]  n);
      logic [31:0] mask;
      logic [5:0]  sh;
      mask = ~(UNMAPPED_READ >> n);
      sh   = DATA_BITS_MAX - n;
      merge_bits = (cur & ~mask) | ((sr << sh) & mask);
   endfunction

   // pins cross into the clock domain through two flops
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         in_s1_ff <= 6'h20;
         in_s2_ff <= 6'h20;
         sle_d_ff <= 1'b1;
         sck_d_ff <= 1'b0;
      end else begin
         in_s1_ff <= {sle_i, sck_i, sdata_i, synth_lock_flag_i,
                      demod_raw_i, tx_data_i};
         in_s2_ff <= in_s1_ff;
         sle_d_ff <= in_s2_ff[5];
         sck_d_ff <= in_s2_ff[4];
      end
   end

   always_comb begin
      sle_s    = in_s2_ff[5];
      sck_s    = in_s2_ff[4];
      sdin_s   = in_s2_ff[3];
      lock_s   = in_s2_ff[2];
      demod_s  = in_s2_ff[1];
      txd_s    = in_s2_ff[0];
      sle_fall = sle_d_ff & ~sle_s;
      sle_rise = ~sle_d_ff & sle_s;
      sck_rise = ~sck_d_ff & sck_s;
      sck_fall = sck_d_ff & ~sck_s;
   end

   // frame engine; sle high is idle so a glitch on sck never writes
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_ff    <= ST_IDLE;
         hdr_cnt_ff  <= 3'h0;
         addr_ff     <= 4'h0;
         wr_cnt_ff   <= 6'h00;
         wr_sr_ff    <= 32'h00000000;
         rd_sr_ff    <= 32'h00000000;
         written_ff  <= 1'b0;
         sdata_ff    <= 1'b0;
         sdata_oe_ff <= 1'b0;
      end else if (sle_rise) begin
         state_ff    <= ST_IDLE;
         sdata_oe_ff <= 1'b0;
         sdata_ff    <= 1'b0;
      end else if (sle_fall) begin
         state_ff    <= ST_ADDR;
         hdr_cnt_ff  <= 3'h0;
      end else begin
         case (state_ff)
            ST_ADDR: begin
               if (sck_rise) begin
                  hdr_cnt_ff <= hdr_cnt_ff + 3'h1;
                  if (hdr_cnt_ff != HDR_LAST_BIT) begin
                     addr_ff <= {addr_ff[2:0], sdin_s};
                  end else if (sdin_s) begin
                     state_ff   <= ST_WRITE;
                     wr_cnt_ff  <= 6'h00;
                     written_ff <= 1'b0;
                  end else begin
                     state_ff <= ST_READ;
                     // unmapped addresses read ones then zeros
                     if (addr_ff == ADDR_MAIN_CONTROL) begin
                        rd_sr_ff <= main_control_ff;
                     end else begin
                        rd_sr_ff <= UNMAPPED_READ;
                     end
                  end
               end
            end
            ST_WRITE: begin
               if (sck_rise) begin
                  if (wr_cnt_ff != DATA_BITS_MAX) begin
                     wr_sr_ff  <= {wr_sr_ff[30:0], sdin_s};
                     wr_cnt_ff <= wr_cnt_ff + 6'h01;
                  end else begin
                     written_ff <= 1'b1;
                  end
               end
            end
            ST_READ: begin
               // zeros shift in, so overlong reads clamp to zero
               if (sck_fall) begin
                  sdata_oe_ff <= 1'b1;
                  sdata_ff    <= rd_sr_ff[31];
                  rd_sr_ff    <= {rd_sr_ff[30:0], 1'b0};
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   always_comb begin
      commit_full = (state_ff == ST_WRITE) && sck_rise && !sle_rise
                    && !sle_fall && (wr_cnt_ff == DATA_BITS_MAX)
                    && !written_ff && (addr_ff == ADDR_MAIN_CONTROL);
      commit_part = sle_rise && (state_ff == ST_WRITE) && !written_ff
                    && (wr_cnt_ff != 6'h00)
                    && (addr_ff == ADDR_MAIN_CONTROL);
      soft_reset  = sle_rise && (state_ff == ST_WRITE)
                    && (wr_cnt_ff != 6'h00)
                    && (addr_ff == ADDR_SOFT_RESET);
      nxt_main_control = merge_bits(main_control_ff, wr_sr_ff, wr_cnt_ff);
   end

   // reserved and crystal bits are stored as the host writes them
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || soft_reset) begin
         main_control_ff <= MAIN_CONTROL_RESET;
      end else if (commit_full || commit_part) begin
         main_control_ff <= nxt_main_control;
      end
   end

   // shared converter: a supply reading freezes the rssi result
   always_comb begin
      rssi_sample = adc_valid_i && main_control_ff[POS_POWER]
                    && !main_control_ff[POS_MEASURE_SEL];
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         signal_level_ff <= 6'h00;
         supply_ff       <= 6'h00;
      end else if (adc_valid_i && main_control_ff[POS_POWER]) begin
         if (!main_control_ff[POS_MEASURE_SEL]) begin
            signal_level_ff <= adc_sample_i;
         end else begin
            supply_ff <= adc_sample_i;
         end
      end
   end

   signal_gate u_signal_gate (
      .sys_clk_i      (sys_clk_i),
      .rst_i          (rst_i),
      .sample_valid_i (rssi_sample),
      .level_i        (adc_sample_i),
      .threshold_i    (main_control_ff[POS_THRESHOLD_HI:POS_THRESHOLD_LO]),
      .hysteresis_i   (main_control_ff[POS_HYSTERESIS_HI:POS_HYSTERESIS_LO]),
      .pass_o         (gate_pass)
   );

   // control outputs, all registered; power-down masks the core
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         core_active_o          <= 1'b0;
         transmit_mode_o        <= 1'b0;
         recovered_clock_run_o  <= 1'b0;
         amplifier_on_o         <= 1'b0;
         wakeup_run_o           <= 1'b0;
         low_noise_min_gain_o   <= 1'b0;
         transmit_power_level_o <= 3'h0;
         freq_reg_index_o       <= 2'h2;
         discriminator_narrow_o <= 1'b0;
         slicer_internal_ref_o  <= 1'b1;
         converter_route_o      <= CONV_RSSI;
         demodulated_data_out_o <= 1'b0;
         extended_mode_o        <= 1'b0;
      end else begin
         core_active_o   <= main_control_ff[POS_POWER];
         transmit_mode_o <= main_control_ff[POS_DIRECTION];
         recovered_clock_run_o <= main_control_ff[POS_POWER]
                                  & main_control_ff[POS_RECOVERED_CLK];
         amplifier_on_o <= main_control_ff[POS_POWER]
                           & main_control_ff[POS_AMPLIFIER]
                           & main_control_ff[POS_DIRECTION]
                           & (lock_s | ~main_control_ff[POS_LOCK_GATED]);
         wakeup_run_o <= main_control_ff[POS_POWER]
                         & main_control_ff[POS_WAKEUP];
         low_noise_min_gain_o <= main_control_ff[POS_LOW_NOISE_GAIN];
         transmit_power_level_o <=
            main_control_ff[POS_TX_LEVEL_HI:POS_TX_LEVEL_LO];
         if (main_control_ff[POS_DIRECTION]) begin
            freq_reg_index_o <= {main_control_ff[POS_TX_FREQ_SET],
                                 txd_s};
         end else begin
            freq_reg_index_o <=
               main_control_ff[POS_RX_FREQ_HI:POS_RX_FREQ_LO];
         end
         discriminator_narrow_o <= ~main_control_ff[POS_EXTENDED]
                                   & ~main_control_ff[POS_DISC_BW];
         slicer_internal_ref_o <= main_control_ff[POS_SLICER_REF];
         if (!main_control_ff[POS_MEASURE_SEL]) begin
            converter_route_o <= CONV_RSSI;
         end else if (main_control_ff[POS_CONV_SOURCE]) begin
            converter_route_o <= CONV_DISC_DC;
         end else begin
            converter_route_o <= CONV_SUPPLY;
         end
         demodulated_data_out_o <= main_control_ff[POS_POWER] & gate_pass
            & (main_control_ff[POS_POLARITY] ? demod_s : ~demod_s);
         extended_mode_o <= main_control_ff[POS_EXTENDED];
      end
   end

   assign sdata_o                 = sdata_ff;
   assign sdata_oe_o              = sdata_oe_ff;
   assign main_control_o          = main_control_ff;
   assign measured_signal_level_o = signal_level_ff;
   assign measured_supply_o       = supply_ff;

   sequence s_read_turn;
      (state_ff == ST_READ) && sck_fall && !sle_rise && !sle_fall;
   endsequence

   property p_read_drives;
      @(posedge sys_clk_i) disable iff (rst_i)
      s_read_turn |=> sdata_oe_o;
   endproperty
   a_read_drives: assert property (p_read_drives)
      else $error("read data not driven after turnaround");

   property p_oe_only_reading;
      @(posedge sys_clk_i) disable iff (rst_i)
      sdata_oe_o |-> (state_ff == ST_READ);
   endproperty
   a_oe_only_reading: assert property (p_oe_only_reading)
      else $error("data pin driven outside a read");

   property p_reset_value;
      @(posedge sys_clk_i)
      rst_i |=> (main_control_o == MAIN_CONTROL_RESET);
   endproperty
   a_reset_value: assert property (p_reset_value)
      else $error("control register not at reset value");

   property p_amp_needs_power;
      @(posedge sys_clk_i) disable iff (rst_i)
      amplifier_on_o |-> $past(main_control_ff[POS_POWER])
                         && $past(main_control_ff[POS_AMPLIFIER]);
   endproperty
   a_amp_needs_power: assert property (p_amp_needs_power)
      else $error("amplifier on without power or enable");

   property p_amp_lock;
      @(posedge sys_clk_i) disable iff (rst_i)
      amplifier_on_o && $past(main_control_ff[POS_LOCK_GATED])
         |-> $past(lock_s);
   endproperty
   a_amp_lock: assert property (p_amp_lock)
      else $error("amplifier on while synthesizer unlocked");

   property p_clock_silent;
      @(posedge sys_clk_i) disable iff (rst_i)
      !main_control_ff[POS_RECOVERED_CLK] |=> !recovered_clock_run_o;
   endproperty
   a_clock_silent: assert property (p_clock_silent)
      else $error("recovered clock runs while disabled");

   property p_wakeup_off;
      @(posedge sys_clk_i) disable iff (rst_i)
      !main_control_ff[POS_WAKEUP] |=> !wakeup_run_o;
   endproperty
   a_wakeup_off: assert property (p_wakeup_off)
      else $error("wakeup runs while disabled");

   property p_rx_index;
      @(posedge sys_clk_i) disable iff (rst_i)
      !main_control_ff[POS_DIRECTION] |=>
         freq_reg_index_o == $past(main_control_ff[9:8]);
   endproperty
   a_rx_index: assert property (p_rx_index)
      else $error("receive register index wrong");

   property p_rssi_frozen;
      @(posedge sys_clk_i) disable iff (rst_i)
      main_control_ff[POS_MEASURE_SEL] |=> $stable(measured_signal_level_o);
   endproperty
   a_rssi_frozen: assert property (p_rssi_frozen)
      else $error("rssi result changed during supply measurement");

   property p_no_supply_off;
      @(posedge sys_clk_i) disable iff (rst_i)
      !main_control_ff[POS_POWER] |=> $stable(measured_supply_o);
   endproperty
   a_no_supply_off: assert property (p_no_supply_off)
      else $error("supply reading taken while powered down");

   property p_data_polarity;
      @(posedge sys_clk_i) disable iff (rst_i)
      demodulated_data_out_o |->
         $past(demod_s) == $past(main_control_ff[POS_POLARITY]);
   endproperty
   a_data_polarity: assert property (p_data_polarity)
      else $error("data output polarity wrong");

endmodule // main_control
`default_nettype wire

//--- main_control_pkg.sv
// constants for the transceiver main control register block
// assumes a single 100 MHz system clock and a synchronous reset
package main_control_pkg;

   localparam int unsigned   CTRL_W             = 32;
   localparam logic [3:0]    ADDR_MAIN_CONTROL  = 4'h4;
   localparam logic [3:0]    ADDR_SOFT_RESET    = 4'hB;
   localparam logic [31:0]   MAIN_CONTROL_RESET = 32'h10000270;
   localparam logic [31:0]   UNMAPPED_READ      = 32'hFFFFFFFF;

   // field positions inside main_control
   localparam int unsigned   POS_POWER          = 31;
   localparam int unsigned   POS_DIRECTION      = 30;
   localparam int unsigned   POS_RECOVERED_CLK  = 29;
   localparam int unsigned   POS_LOCK_GATED     = 28;
   localparam int unsigned   POS_AMPLIFIER      = 27;
   localparam int unsigned   POS_WAKEUP         = 26;
   localparam int unsigned   POS_LOW_NOISE_GAIN = 25;
   localparam int unsigned   POS_MEASURE_SEL    = 24;
   localparam int unsigned   POS_THRESHOLD_HI   = 23;
   localparam int unsigned   POS_THRESHOLD_LO   = 18;
   localparam int unsigned   POS_HYSTERESIS_HI  = 17;
   localparam int unsigned   POS_HYSTERESIS_LO  = 15;
   localparam int unsigned   POS_TX_LEVEL_HI    = 14;
   localparam int unsigned   POS_TX_LEVEL_LO    = 12;
   localparam int unsigned   POS_TX_FREQ_SET    = 11;
   localparam int unsigned   POS_RX_FREQ_HI     = 9;
   localparam int unsigned   POS_RX_FREQ_LO     = 8;
   localparam int unsigned   POS_CRYSTAL        = 7;
   localparam int unsigned   POS_DISC_BW        = 6;
   localparam int unsigned   POS_POLARITY       = 5;
   localparam int unsigned   POS_SLICER_REF     = 4;
   localparam int unsigned   POS_CONV_SOURCE    = 1;
   localparam int unsigned   POS_EXTENDED       = 0;

   // serial frame: 4 address bits then the direction bit
   localparam logic [2:0]    HDR_LAST_BIT       = 3'h4;
   localparam logic [5:0]    DATA_BITS_MAX      = 6'h20;

   // converter routing codes
   localparam logic [1:0]    CONV_RSSI          = 2'h0;
   localparam logic [1:0]    CONV_SUPPLY        = 2'h1;
   localparam logic [1:0]    CONV_DISC_DC       = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ADDR  = 2'b01,
      ST_WRITE = 2'b10,
      ST_READ  = 2'b11
   } serial_state_type;

endpackage

//--- signal_gate.sv
// signal-level hysteresis gate for the demodulated data output
// assumes level samples arrive on the system clock with a valid strobe
`timescale 1ns/1ps
`default_nettype none
module signal_gate (
   input  wire logic       sys_clk_i,
   input  wire logic       rst_i,
   input  wire logic       sample_valid_i,
   input  wire logic [5:0] level_i,
   input  wire logic [5:0] threshold_i,
   input  wire logic [2:0] hysteresis_i,
   output logic            pass_o
);
   import main_control_pkg::*;

   logic [6:0] high_level;
   logic [5:0] low_level;
   logic       pass_ff;

   always_comb begin
      high_level = {1'b0, threshold_i} + {4'h0, hysteresis_i};
      // floor at zero so a large hysteresis never wraps the low level
      if (threshold_i >= {3'h0, hysteresis_i}) begin
         low_level = threshold_i - {3'h0, hysteresis_i};
      end else begin
         low_level = 6'h00;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         pass_ff <= 1'b0;
      end else if (sample_valid_i) begin
         if ({1'b0, level_i} >= high_level) begin
            pass_ff <= 1'b1;
         end else if (level_i < low_level) begin
            pass_ff <= 1'b0;
         end
      end
   end

   assign pass_o = pass_ff;

   property p_gate_open;
      @(posedge sys_clk_i) disable iff (rst_i)
      sample_valid_i && ({1'b0, level_i} >= high_level) |=> pass_o;
   endproperty
   a_gate_open: assert property (p_gate_open)
      else $error("gate did not open at high level");

   property p_gate_floor;
      @(posedge sys_clk_i) disable iff (rst_i)
      sample_valid_i && pass_o
         && (threshold_i < {3'h0, hysteresis_i}) |=> pass_o;
   endproperty
   a_gate_floor: assert property (p_gate_floor)
      else $error("gate closed although low level floors at zero");

endmodule // signal_gate
`default_nettype wire

//--- host_serial.sv
// host side of the three-wire register port, frames driven by tasks
// assumes the bench resolves the shared data wire from the device enable
`timescale 1ns/1ps
`default_nettype none
module host_serial (
   input  wire logic sys_clk_i,
   input  wire logic line_i,
   output logic      sle_o,
   output logic      sck_o,
   output logic      sdata_o
);
   initial begin
      sle_o   = 1'b1;
      sck_o   = 1'b0;
      sdata_o = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask

   // address msb first, then r/w, then data msb first
   task automatic xfer(input logic [3:0] a, input logic w,
                       input logic [31:0] d, input int n,
                       output logic [31:0] q);
      logic [36:0] bits;
      bits  = {a, w, d};
      q     = '0;
      sle_o = 1'b0;
      tick(8);
      for (int i = 0; i < 5 + n; i++) begin
         // released line toggles so a stale level never reads as data
         if (i < 5 || w) sdata_o = bits[36-i];
         else sdata_o = ~sdata_o;
         // 8 clk per phase keeps well above the 4 clk minimum
         tick(8);
         if (i >= 5) q = {q[30:0], line_i};
         sck_o = 1'b1;
         tick(8);
         sck_o = 1'b0;
      end
      tick(8);
      sle_o   = 1'b1;
      sdata_o = ~sdata_o;
      tick(12);
   endtask
endmodule // host_serial
`default_nettype wire

//--- main_control_test.sv
// self-checking bench for the main control register block
// assumes the host model drives the serial pins through its tasks
`timescale 1ns/1ps
`default_nettype none
module main_control_test;
   import main_control_pkg::*;
   logic        sys_clk, rst, lock, raw, txd, adc_v, sle, sck, hsd;
   logic        dsd, doe, core, txm, rclk, amp, wake, gain;
   logic        disc, sref, dout, ext;
   logic [5:0]  adc_s, msig, msup;
   logic [31:0] reg_q, q;
   logic [2:0]  lvl;
   logic [1:0]  fidx, route;
   int          num_errors = 0;
   int          samples_checked = 0;
   logic [5:0]  seq [10] = '{6'h1B, 6'h20, 6'h23, 6'h24, 6'h23,
                             6'h20, 6'h1D, 6'h1C, 6'h1B, 6'h19};
   logic [9:0]  pass_exp = 10'h07C;
   wire         line = doe ? dsd : hsd;

   host_serial u_host (.sys_clk_i(sys_clk), .line_i(line),
      .sle_o(sle), .sck_o(sck), .sdata_o(hsd));

   main_control u_dut (.sys_clk_i(sys_clk), .rst_i(rst), .sle_i(sle),
      .sck_i(sck), .sdata_i(line), .sdata_o(dsd), .sdata_oe_o(doe),
      .synth_lock_flag_i(lock), .demod_raw_i(raw), .tx_data_i(txd),
      .adc_valid_i(adc_v), .adc_sample_i(adc_s), .main_control_o(reg_q),
      .core_active_o(core), .transmit_mode_o(txm),
      .recovered_clock_run_o(rclk), .amplifier_on_o(amp),
      .wakeup_run_o(wake), .low_noise_min_gain_o(gain),
      .transmit_power_level_o(lvl), .freq_reg_index_o(fidx),
      .discriminator_narrow_o(disc), .slicer_internal_ref_o(sref),
      .converter_route_o(route), .measured_signal_level_o(msig),
      .measured_supply_o(msup), .demodulated_data_out_o(dout),
      .extended_mode_o(ext));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic close_out();
      $display("compared %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // reserved bits and crystal field always written as zero
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input int n);
      u_host.xfer(a, 1'b1, d, n, q);
   endtask

   task automatic adc(input logic [5:0] v);
      adc_s = v;
      adc_v = 1'b1;
      u_host.tick(1);
      adc_v = 1'b0;
      u_host.tick(3);
   endtask

   // whole run is about 6000 clocks, so this only cuts a hang
   initial begin
      repeat (60000) @(posedge sys_clk);
      num_errors++;
      close_out();
   end

   initial begin
      // converter strobe stays low until a test sends a sample
      rst   = 1'b1;
      lock  = 1'b0;
      raw   = 1'b1;
      txd   = 1'b1;
      adc_v = 1'b0;
      adc_s = 6'h00;
      repeat (16) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      u_host.tick(4);
      chk("reset value", MAIN_CONTROL_RESET, reg_q);
      chk("reset index", 32'h2, fidx);
      chk("reset slicer", 32'h1, sref);
      chk("reset direction", 32'h0, txm);
      chk("reset level", 32'h0, lvl);
      chk("reset power", 32'h0, core);
      wr(ADDR_MAIN_CONTROL, 32'hFE005A30, 32);
      u_host.xfer(ADDR_MAIN_CONTROL, 1'b0, 32'h0, 32, q);
      chk("readback", 32'hFE005A30, q);
      chk("core", 32'h1, core);
      chk("direction", 32'h1, txm);
      chk("recovery", 32'h1, rclk);
      chk("amp unlocked", 32'h0, amp);
      lock = 1'b1;
      u_host.tick(6);
      chk("amp locked", 32'h1, amp);
      chk("wakeup", 32'h1, wake);
      chk("gain", 32'h1, gain);
      chk("tx level", 32'h5, lvl);
      chk("tx index one", 32'h3, fidx);
      txd = 1'b0;
      u_host.tick(6);
      chk("tx index zero", 32'h2, fidx);
      chk("narrow", 32'h1, disc);
      wr(ADDR_MAIN_CONTROL, 32'hFE005A31, 32);
      chk("extended", 32'h1, ext);
      chk("narrow ext", 32'h0, disc);
      wr(ADDR_MAIN_CONTROL, 32'h40000000, 2);
      chk("partial", 32'h7E005A31, reg_q);
      chk("core off", 32'h0, core);
      chk("amp off", 32'h0, amp);
      chk("recovery off", 32'h0, rclk);
      chk("wakeup off", 32'h0, wake);
      // threshold 32, hysteresis 4, receive, direct polarity
      wr(ADDR_MAIN_CONTROL, 32'h80820230, 32);
      for (int i = 0; i < 10; i++) begin
         adc(seq[i]);
         chk("rssi", seq[i], msig);
         chk("gate", pass_exp[9-i], dout);
      end
      adc(6'h28);
      wr(ADDR_MAIN_CONTROL, 32'h80820210, 32);
      raw = 1'b0;
      u_host.tick(6);
      chk("inverted", 32'h1, dout);
      // threshold 2, hysteresis 5: low level floors at zero
      wr(ADDR_MAIN_CONTROL, 32'h800A8210, 32);
      adc(6'h00);
      chk("floor hold", 32'h1, dout);
      wr(ADDR_MAIN_CONTROL, 32'h81820210, 32);
      adc(6'h11);
      chk("supply", 32'h11, msup);
      chk("rssi kept", 32'h0, msig);
      chk("route", 32'h1, route);
      wr(ADDR_MAIN_CONTROL, 32'h81820212, 32);
      chk("route disc", 32'h2, route);
      // power off keeps measure select, so a sample must be dropped
      wr(ADDR_MAIN_CONTROL, 32'h00000000, 1);
      adc(6'h2A);
      chk("supply off", 32'h11, msup);
      chk("core off again", 32'h0, core);
      u_host.xfer(4'hC, 1'b0, 32'h0, 32, q);
      chk("unmapped", UNMAPPED_READ, q);
      wr(ADDR_SOFT_RESET, 32'h80000000, 1);
      chk("soft reset", MAIN_CONTROL_RESET, reg_q);
      close_out();
   end
endmodule // main_control_test
`default_nettype wire
